/* File: hw/rtcc_core.sv */
// control, status and trickle-charge configuration logic of the clock chip
`timescale 1ns/1ps
`default_nettype none

module rtcc_core (
    // clock and power-up reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register file port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // time base and power state
    input wire logic XTAL_32K,
    input wire logic OSC_RUNNING,
    input wire logic ON_BACKUP,
    input wire logic ALARM1_MATCH,
    input wire logic ALARM2_MATCH,
    // shared open-drain wave/interrupt pin
    output logic WAVE_IRQ_OUT,
    output logic WAVE_IRQ_OE,
    // oscillator and charger controls
    output logic OSC_DISABLE,
    output logic CHARGE_ON,
    output logic CHARGE_DIODE,
    output logic [1:0] CHARGE_RES
);

    rtcc_pkg::rtcc_state_t st;
    rtcc_pkg::rtcc_state_t next_st;
    rtcc_pkg::rtcc_req_t req;

    logic wr_ctl;
    logic wr_sts;
    logic wr_trk;
    logic osc_fell;
    logic dis_rose;
    logic irq_req;
    logic wave;
    logic drive;
    logic trk_ok;

    assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        next_st = st;
        wr_ctl = req.wr && (req.addr == rtcc_pkg::ADDR_CONTROL);
        wr_sts = req.wr && (req.addr == rtcc_pkg::ADDR_STATUS);
        wr_trk = req.wr && (req.addr == rtcc_pkg::ADDR_TRICKLE);

        // control: bit 6 is not writable
        if (wr_ctl) begin
            next_st.ctrl = req.wdata & rtcc_pkg::CTL_WRITE_MASK;
        end
        if (wr_trk) begin
            next_st.trickle = req.wdata;
        end

        // stop flag: falling run indication or the disable bit going high
        osc_fell = st.osc_prev && !OSC_RUNNING;
        dis_rose = next_st.ctrl[rtcc_pkg::CTL_OSC_DIS] && !st.ctrl[rtcc_pkg::CTL_OSC_DIS];
        next_st.osc_prev = OSC_RUNNING;
        // write-zero-to-clear; a set in the same cycle wins
        if (wr_sts && !req.wdata[rtcc_pkg::STS_OSF]) begin
            next_st.osc_stopped_flag = 1'b0;
        end
        if (wr_sts && !req.wdata[rtcc_pkg::STS_A2F]) begin
            next_st.a2f = 1'b0;
        end
        if (wr_sts && !req.wdata[rtcc_pkg::STS_A1F]) begin
            next_st.a1f = 1'b0;
        end
        if (osc_fell || dis_rose) begin
            next_st.osc_stopped_flag = 1'b1;
        end
        if (ALARM2_MATCH) begin
            next_st.a2f = 1'b1;
        end
        if (ALARM1_MATCH) begin
            next_st.a1f = 1'b1;
        end

        // readback; reserved bits and unmapped addresses read zero
        if (req.rd) begin
            case (req.addr)
                rtcc_pkg::ADDR_CONTROL: next_st.rdata = st.ctrl;
                rtcc_pkg::ADDR_STATUS: next_st.rdata = {st.osc_stopped_flag, 5'h00, st.a2f, st.a1f};
                rtcc_pkg::ADDR_TRICKLE: next_st.rdata = st.trickle;
                default: next_st.rdata = 8'h00;
            endcase
        end

        // divider counts crystal rising edges; halted crystal freezes the wave
        next_st.xq = XTAL_32K;
        if (XTAL_32K && !st.xq) begin
            next_st.div = st.div + 15'h0001;
        end
        case ({st.ctrl[rtcc_pkg::CTL_RATE_HI], st.ctrl[rtcc_pkg::CTL_RATE_LO]})
            rtcc_pkg::RATE_1HZ: wave = st.div[rtcc_pkg::TAP_1HZ];
            rtcc_pkg::RATE_4K: wave = st.div[rtcc_pkg::TAP_4K];
            rtcc_pkg::RATE_8K: wave = st.div[rtcc_pkg::TAP_8K];
            rtcc_pkg::RATE_32K: wave = st.xq;
            default: wave = 1'b1;
        endcase

        // interrupt is active low and holds while any enabled flag stands
        irq_req = (st.a1f && st.ctrl[rtcc_pkg::CTL_A1_IE])
            || (st.a2f && st.ctrl[rtcc_pkg::CTL_A2_IE]);
        drive = !(ON_BACKUP && !st.ctrl[rtcc_pkg::CTL_BACKUP_OE]);
        next_st.pin_out = 1'b0;
        if (st.ctrl[rtcc_pkg::CTL_IRQ_SEL]) begin
            next_st.pin_oe = drive && irq_req;
        end else begin
            next_st.pin_oe = drive && !wave;
        end

        // charger needs key, a legal diode choice and a resistor
        trk_ok = (st.trickle[7:4] == rtcc_pkg::TRICKLE_KEY)
            && ((st.trickle[3:2] == rtcc_pkg::DIODE_NONE)
            || (st.trickle[3:2] == rtcc_pkg::DIODE_ONE))
            && (st.trickle[1:0] != rtcc_pkg::RES_OFF);
        next_st.chg_on = trk_ok;
        next_st.chg_diode = trk_ok && (st.trickle[3:2] == rtcc_pkg::DIODE_ONE);
        next_st.chg_res = trk_ok ? st.trickle[1:0] : rtcc_pkg::RES_OFF;
        next_st.osc_dis = st.ctrl[rtcc_pkg::CTL_OSC_DIS];
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.ctrl <= rtcc_pkg::CONTROL_RESET;
            st.trickle <= rtcc_pkg::TRICKLE_RESET;
            st.osc_stopped_flag <= rtcc_pkg::OSF_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign REG_RDATA = st.rdata;
    assign WAVE_IRQ_OUT = st.pin_out;
    assign WAVE_IRQ_OE = st.pin_oe;
    assign OSC_DISABLE = st.osc_dis;
    assign CHARGE_ON = st.chg_on;
    assign CHARGE_DIODE = st.chg_diode;
    assign CHARGE_RES = st.chg_res;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    wave_select_a:
    assert property (!st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && !ON_BACKUP
        && st.ctrl[rtcc_pkg::CTL_RATE_HI] && st.ctrl[rtcc_pkg::CTL_RATE_LO]
        |=> WAVE_IRQ_OE == !$past(st.xq))
    else $error("32k square wave not on pin");

    alarm_irq_a:
    assert property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && !ON_BACKUP
        && st.a1f && st.ctrl[rtcc_pkg::CTL_A1_IE] |=> WAVE_IRQ_OE)
    else $error("enabled alarm 1 not asserting pin");

    alarm2_gate_a:
    assert property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && !st.ctrl[rtcc_pkg::CTL_A1_IE]
        && !st.ctrl[rtcc_pkg::CTL_A2_IE] |=> !WAVE_IRQ_OE)
    else $error("interrupt with both enables clear");

    osf_edge_set_a:
    assert property ($fell(OSC_RUNNING) |=> st.osc_stopped_flag)
    else $error("stop flag missed oscillator stop");

    osf_write_one_a:
    assert property (wr_sts && req.wdata[rtcc_pkg::STS_OSF] && !st.osc_stopped_flag
        && !osc_fell && !dis_rose |=> !st.osc_stopped_flag)
    else $error("writing 1 set the stop flag");

    a1_set_hold_a:
    assert property (ALARM1_MATCH |=> st.a1f ##1 (st.a1f || $past(wr_sts)))
    else $error("alarm 1 flag not set or lost");

    a2_clear_a:
    assert property (wr_sts && !req.wdata[rtcc_pkg::STS_A2F] && !ALARM2_MATCH |=> !st.a2f)
    else $error("alarm 2 flag not cleared");

    charge_key_a:
    assert property (st.trickle[7:4] != rtcc_pkg::TRICKLE_KEY |=> !CHARGE_ON)
    else $error("charger on without key");

    charge_decode_a:
    assert property (st.trickle == 8'hA6 |=> CHARGE_ON && !CHARGE_DIODE && CHARGE_RES == 2'h2)
    else $error("trickle decode wrong");

    backup_float_a:
    assert property (ON_BACKUP && !st.ctrl[rtcc_pkg::CTL_BACKUP_OE] |=> !WAVE_IRQ_OE)
    else $error("pin driven on backup");

    reserved_zero_a:
    assert property (req.rd && req.addr == rtcc_pkg::ADDR_STATUS |=> REG_RDATA[6:2] == 5'h00)
    else $error("reserved status bits not zero");

    // first edge out of reset still sees the power-up values
    reset_values_a:
    assert property ($fell(RST) |-> st.ctrl == rtcc_pkg::CONTROL_RESET
        && st.trickle == rtcc_pkg::TRICKLE_RESET && st.osc_stopped_flag && !st.a2f && !st.a1f)
    else $error("power-up register values wrong");

    osf_disable_set_a:
    assert property (wr_ctl && req.wdata[rtcc_pkg::CTL_OSC_DIS]
        && !st.ctrl[rtcc_pkg::CTL_OSC_DIS] |=> st.osc_stopped_flag)
    else $error("stop flag missed oscillator disable");

    osf_hold_a:
    assert property (st.osc_stopped_flag && !(wr_sts && !req.wdata[rtcc_pkg::STS_OSF]) |=> st.osc_stopped_flag)
    else $error("stop flag lost without a clearing write");

    a2_set_a:
    assert property (ALARM2_MATCH |=> st.a2f)
    else $error("alarm 2 flag not set by match");

    a1_clear_a:
    assert property (wr_sts && !req.wdata[rtcc_pkg::STS_A1F] && !ALARM1_MATCH |=> !st.a1f)
    else $error("alarm 1 flag not cleared");

    // a match in the same cycle may still set the flag
    a2_write_one_a:
    assert property (wr_sts && req.wdata[rtcc_pkg::STS_A2F]
        |=> st.a2f == ($past(st.a2f) || $past(ALARM2_MATCH)))
    else $error("writing 1 changed alarm 2 flag");

    a1_hold_a:
    assert property (st.a1f && !(wr_sts && !req.wdata[rtcc_pkg::STS_A1F]) |=> st.a1f)
    else $error("alarm 1 flag dropped before clear");

    // interrupt mode never shows the wave, even with no flag up
    irq_only_a:
    assert property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL]
        && !(st.a1f && st.ctrl[rtcc_pkg::CTL_A1_IE])
        && !(st.a2f && st.ctrl[rtcc_pkg::CTL_A2_IE]) |=> !WAVE_IRQ_OE)
    else $error("pin pulled in interrupt mode without enabled flag");

    alarm1_gate_a:
    assert property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && st.a1f
        && !st.ctrl[rtcc_pkg::CTL_A1_IE]
        && !(st.a2f && st.ctrl[rtcc_pkg::CTL_A2_IE]) |=> !WAVE_IRQ_OE)
    else $error("disabled alarm 1 asserted pin");

    wave_8k_a:
    assert property (!st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && !ON_BACKUP
        && st.ctrl[rtcc_pkg::CTL_RATE_HI] && !st.ctrl[rtcc_pkg::CTL_RATE_LO]
        |=> WAVE_IRQ_OE == !$past(st.div[rtcc_pkg::TAP_8K]))
    else $error("8k square wave not on pin");

    no_diode_a:
    assert property (st.trickle[3:2] == 2'h0 || st.trickle[3:2] == 2'h3
        |=> !CHARGE_ON && !CHARGE_DIODE)
    else $error("charger on with illegal diode choice");

    res_off_a:
    assert property (st.trickle[1:0] == rtcc_pkg::RES_OFF
        |=> !CHARGE_ON && CHARGE_RES == rtcc_pkg::RES_OFF)
    else $error("charger on without resistor");

    // ************************************************************
    // cover points
    // ************************************************************
    irq_seen_c: cover property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && WAVE_IRQ_OE);
    osf_cleared_c: cover property ($fell(st.osc_stopped_flag));
    charger_on_c: cover property (CHARGE_ON && CHARGE_DIODE);
    alarm2_irq_c: cover property (st.ctrl[rtcc_pkg::CTL_IRQ_SEL] && st.a2f && WAVE_IRQ_OE);
    backup_wave_c: cover property (ON_BACKUP && WAVE_IRQ_OE);

endmodule

`default_nettype wire

/* File: hw/rtcc_pkg.sv */
// package: register map, field positions and reset values of the control/status/trickle block
package rtcc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_STATUS = 8'h0F;
    localparam logic [7:0] ADDR_TRICKLE = 8'h10;
    // control field positions
    localparam int CTL_OSC_DIS = 7;
    localparam int CTL_BACKUP_OE = 5;
    localparam int CTL_RATE_HI = 4;
    localparam int CTL_RATE_LO = 3;
    localparam int CTL_IRQ_SEL = 2;
    localparam int CTL_A2_IE = 1;
    localparam int CTL_A1_IE = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hBF;
    // status field positions
    localparam int STS_OSF = 7;
    localparam int STS_A2F = 1;
    localparam int STS_A1F = 0;
    // trickle fields
    localparam logic [3:0] TRICKLE_KEY = 4'hA;
    localparam logic [1:0] DIODE_NONE = 2'h1;
    localparam logic [1:0] DIODE_ONE = 2'h2;
    localparam logic [1:0] RES_OFF = 2'h0;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h18;
    localparam logic [7:0] TRICKLE_RESET = 8'h00;
    localparam logic OSF_RESET = 1'b1;
    // square-wave divider taps on a 32.768 kHz edge counter
    localparam int DIV_WIDTH = 15;
    localparam int TAP_8K = 1;
    localparam int TAP_4K = 2;
    localparam int TAP_1HZ = 14;
    localparam logic [1:0] RATE_1HZ = 2'h0;
    localparam logic [1:0] RATE_4K = 2'h1;
    localparam logic [1:0] RATE_8K = 2'h2;
    localparam logic [1:0] RATE_32K = 2'h3;

    typedef struct packed {
        logic [7:0] ctrl;
        logic osc_stopped_flag;
        logic a2f;
        logic a1f;
        logic [7:0] trickle;
        logic [7:0] rdata;
        logic xq;
        logic osc_prev;
        logic [DIV_WIDTH-1:0] div;
        logic pin_out;
        logic pin_oe;
        logic osc_dis;
        logic chg_on;
        logic chg_diode;
        logic [1:0] chg_res;
    } rtcc_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcc_req_t;
endpackage

/* File: tb/rtcc_host.sv */
// host model that reaches the control/status/trickle registers
`timescale 1ns/1ps
`default_nettype none

module rtcc_host #(
    parameter int VCC_MV = 3300
) (
    // clock
    input wire logic clk,
    // register port
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // after a write, idle address and data show the inverse of the last value; after a read only the address is inverted and data stays stale
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        // 250 ohm on a high supply would overcharge the backup cell
        if (a == rtcc_pkg::ADDR_TRICKLE && d[1:0] == 2'h1 && VCC_MV > 3630) return;
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
        @(negedge clk);
    endtask

    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the control/status/trickle block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_sys, rst, osc_run, on_backup, m1, m2, oe, out, osc_dis, chg_on, chg_diode;
    logic wr, rd;
    logic [7:0] addr, wdata, rdata, v;
    logic [1:0] xc, chg_res;
    int n_fail = 0;
    int tests_run = 0;

    rtcc_host host (.clk(clk_sys), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));

    rtcc_core uut (.CLK_SYS(clk_sys), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .XTAL_32K(xc[1]), .OSC_RUNNING(osc_run),
        .ON_BACKUP(on_backup), .ALARM1_MATCH(m1), .ALARM2_MATCH(m2), .WAVE_IRQ_OUT(out),
        .WAVE_IRQ_OE(oe), .OSC_DISABLE(osc_dis), .CHARGE_ON(chg_on), .CHARGE_DIODE(chg_diode),
        .CHARGE_RES(chg_res));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host.get(a, v);
        chk(what, exp, v);
    endtask

    // the window spans whole periods at the 32k, 8k and 4k rates and is far shorter than one 1 Hz period, so the count is exact
    task automatic rises(input logic [7:0] e);
        logic [7:0] n;
        logic p;
        n = 8'h00;
        p = oe;
        repeat (256) begin
            @(negedge clk_sys);
            if (oe && !p) n++;
            p = oe;
        end
        chk("wave rises", e, n);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rchk("control", rtcc_pkg::ADDR_CONTROL, 8'h18);
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h80);
        rchk("trickle", rtcc_pkg::ADDR_TRICKLE, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
    endtask

    task automatic t_osf;
        host.put(rtcc_pkg::ADDR_STATUS, 8'hFF);
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h80);
        host.put(rtcc_pkg::ADDR_STATUS, 8'h00);
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h00);
        host.put(rtcc_pkg::ADDR_STATUS, 8'hFF);
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h00);
        osc_run = 1'b0;
        repeat (3) @(negedge clk_sys);
        osc_run = 1'b1;
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h80);
        host.put(rtcc_pkg::ADDR_STATUS, 8'h00);
        host.put(rtcc_pkg::ADDR_CONTROL, 8'h98);
        chk("osc disable", 8'h01, {7'h00, osc_dis});
        rchk("status", rtcc_pkg::ADDR_STATUS, 8'h80);
        host.put(rtcc_pkg::ADDR_CONTROL, 8'h18);
        chk("osc disable", 8'h00, {7'h00, osc_dis});
        host.put(rtcc_pkg::ADDR_STATUS, 8'h00);
    endtask

    task automatic t_alarm;
        for (int i = 0; i < 3; i++) begin
            host.put(rtcc_pkg::ADDR_CONTROL, (i == 2) ? 8'h04 : 8'h07);
            {m2, m1} = (i == 0) ? 2'h1 : ((i == 1) ? 2'h2 : 2'h3);
            @(negedge clk_sys);
            {m2, m1} = 2'h0;
            repeat (2) @(negedge clk_sys);
            v = (i == 0) ? 8'h01 : ((i == 1) ? 8'h02 : 8'h03);
            rchk("status", rtcc_pkg::ADDR_STATUS, v);
            chk("irq", (i == 2) ? 8'h00 : 8'h01, {7'h00, oe});
            chk("pin data", 8'h00, {7'h00, out});
            host.put(rtcc_pkg::ADDR_STATUS, 8'h03);
            rchk("status", rtcc_pkg::ADDR_STATUS, v);
            chk("irq held", (i == 2) ? 8'h00 : 8'h01, {7'h00, oe});
            host.put(rtcc_pkg::ADDR_STATUS, 8'h00);
            chk("irq cleared", 8'h00, {7'h00, oe});
        end
    endtask

    task automatic t_wave;
        for (int r = 0; r < 4; r++) begin
            host.put(rtcc_pkg::ADDR_CONTROL, 8'(r) << 3);
            rises((r == 3) ? 8'h40 : ((r == 2) ? 8'h10 : ((r == 1) ? 8'h08 : 8'h00)));
        end
        on_backup = 1'b1;
        rises(8'h00);
        chk("pin floats", 8'h00, {7'h00, oe});
        host.put(rtcc_pkg::ADDR_CONTROL, 8'h78);
        rises(8'h40);
        rchk("control", rtcc_pkg::ADDR_CONTROL, 8'h38);
        on_backup = 1'b0;
    endtask

    task automatic t_trickle;
        logic [7:0] tv [8] = '{8'hA6, 8'hA9, 8'hA7, 8'hA5, 8'h56, 8'hA2, 8'hAE, 8'hA4};
        logic [3:0] te [8] = '{4'hA, 4'hD, 4'hB, 4'h9, 4'h0, 4'h0, 4'h0, 4'h0};
        for (int i = 0; i < 8; i++) begin
            host.put(rtcc_pkg::ADDR_TRICKLE, tv[i]);
            chk("charger", {4'h0, te[i]}, {4'h0, chg_on, chg_diode, chg_res});
            rchk("trickle", rtcc_pkg::ADDR_TRICKLE, tv[i]);
        end
    endtask

    // ****************************************
    // clock, reset and sequence
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) xc <= rst ? 2'h0 : xc + 2'h1;

    initial begin
        #40000;
        n_fail++;
        test_done;
    end

    initial begin
        rst = 1'b1;
        osc_run = 1'b1;
        on_backup = 1'b0;
        m1 = 1'b0;
        m2 = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_osf;
        t_alarm;
        t_wave;
        t_trickle;
        test_done;
    end
endmodule

`default_nettype wire
